//--- bench/psq_companion.sv
// companion side: drives the suspend request and decodes packet frames
module psq_companion (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // bench command and serial line
  input  wire logic       i_want,
  input  wire logic       i_line,
  // request pin and received packet
  output logic            o_req_n,
  output logic [7:0]      o_word,
  output logic            o_got
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] c;

  // push-pull request pin, changed just after the edge
  always @(posedge i_clk) begin
    #1;
    o_req_n = !i_want;
  end

  // frame decode: two start cycles, eight bits msb first, one end cycle
  always @(posedge i_clk) begin
    o_got <= 1'b0;
    if (!i_rst_n) c <= 4'h0;
    else if (c == 4'h0) c <= {3'h0, i_line};
    else if (c == 4'hb) c <= 4'h0;
    else c <= c + 4'h1;
    if (c >= 4'h2 && c <= 4'h9) o_word <= {o_word[6:0], i_line};
    if (c == 4'ha) o_got <= i_line;
  end
endmodule : psq_companion

//--- bench/psq_sc_asserts.sv
module psq_sc_asserts (
  // clock and reset
  input wire logic       i_core_clk,
  input wire logic       i_rst_n,
  // watched inputs
  input wire logic       i_suspend_request_n,
  input wire logic       i_maskable_interrupt,
  input wire logic       i_maskable_interrupt_enabled,
  input wire logic       i_halt_exec,
  input wire logic       i_halt_cycle_done,
  input wire logic       i_pci_master_busy,
  input wire logic       i_core_idle,
  input wire logic       i_refresh_active,
  input wire logic       i_gfx_pipe_active,
  input wire logic       i_self_refresh_ack,
  // watched outputs
  input wire logic [7:0] o_cfg_rdata,
  input wire logic       o_suspend_ack_n,
  input wire logic       o_pm_packet_out,
  input wire logic       o_halt_cycle_req,
  input wire logic       o_self_refresh_req,
  input wire logic       o_clocks_stop
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  // frame position: 1 is second start cycle, 10 end marker, 11 first low
  logic [3:0] frm_q;
  logic [3:0] frm_d;
  always_comb begin
    frm_d = frm_q + 4'h1;
    if (frm_q == 4'h0) frm_d = {3'h0, o_pm_packet_out};
    else if (frm_q == 4'hb) frm_d = 4'h0;
  end
  always_ff @(posedge i_core_clk) begin
    frm_q <= i_rst_n ? frm_d : 4'h0;
  end

  // halt accepted, then broadcast finished with no master traffic
  sequence s_halt_go;
    i_halt_exec && o_cfg_rdata[3] && o_suspend_ack_n;
  endsequence
  sequence s_bcast_end;
    o_halt_cycle_req && i_halt_cycle_done && !i_pci_master_busy;
  endsequence

  a_pin_off: assert property (((o_cfg_rdata & 8'h88) == 8'h00) [*3] |-> o_suspend_ack_n)
    else $error("ack asserted with both suspend enables clear");
  a_drain_first: assert property ($fell(o_suspend_ack_n) |-> $past(i_core_idle))
    else $error("ack asserted before core drained");
  a_release_time: assert property (
    $rose(i_suspend_request_n) && !o_suspend_ack_n && !i_self_refresh_ack
    ##1 !i_refresh_active [*3] |-> o_suspend_ack_n)
    else $error("ack not released in time after request dropped");
  a_halt_hold: assert property (s_halt_go ##1 !i_halt_cycle_done |-> o_suspend_ack_n)
    else $error("ack asserted before halt broadcast finished");
  a_halt_enter: assert property (s_bcast_end |-> ##[1:2] !o_suspend_ack_n)
    else $error("halt suspend not entered");
  a_maskable_interrupt_exit: assert property (
    (i_maskable_interrupt && i_maskable_interrupt_enabled && i_suspend_request_n && !i_refresh_active) [*7]
    |-> o_suspend_ack_n)
    else $error("interrupt did not end halt suspend");
  a_pci_hold: assert property (i_pci_master_busy [*3] |-> o_suspend_ack_n)
    else $error("ack active during master traffic");
  a_gfx_block: assert property (i_gfx_pipe_active [*4] |-> !o_clocks_stop && !o_self_refresh_req)
    else $error("deep suspend with graphics active");
  a_deep_order: assert property (
    $rose(o_clocks_stop) |-> i_self_refresh_ack && $past(o_self_refresh_req))
    else $error("clocks stopped before self refresh");
  a_start_mark: assert property (frm_q == 4'h1 |-> o_pm_packet_out)
    else $error("start marker shorter than two clocks");
  a_end_mark: assert property (frm_q == 4'ha |-> o_pm_packet_out ##1 !o_pm_packet_out)
    else $error("end marker wrong");
endmodule : psq_sc_asserts

bind psq_suspend_ctrl psq_sc_asserts psq_sc_asserts_i (.*);

//--- bench/psq_suspend_ctrl_bench.sv
module psq_suspend_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import psq_pkg::*;
  logic        clk = 1'b0, run = 1'b1, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, cwr = 1'b0;
  logic        mi = 1'b0, smi_n = 1'b1, preq_n = 1'b1, halt = 1'b0, idle = 1'b1, psv = 1'b0;
  logic        busy = 1'b0, hdone = 1'b0, refr = 1'b0, sra = 1'b0, gfx = 1'b0, want = 1'b0;
  logic        rdv = 1'b0, got, ack_n, line, req_n, hreq, srq, cstop, ipend, spend;
  logic        ien = 1'b1, stall;
  logic [15:0] addr = 16'h0;
  logic [31:0] wd = 32'h0, rdata, rq[$], pq[$];
  logic [7:0]  cwd = 8'h0, crd, ev = 8'h0, word, v, e;
  logic [7:0]  ivl [4] = '{PSQ_IVL0_CYC, PSQ_IVL1_CYC, PSQ_IVL2_CYC, PSQ_IVL3_CYC};
  int          n_errors = 0, samples_checked = 0, seed = 33, cyc = 0, n, t, g;

  // clock stops low while run is clear
  initial forever #25 clk = ~clk & run;

  psq_suspend_ctrl psq_suspend_ctrl_i (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_reg_wr_en(wr), .i_reg_rd_en(rd),
    .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdata), .i_cfg_wr_en(cwr),
    .i_cfg_index(PSQ_IDX_CFG_TWO), .i_cfg_wdata(cwd), .o_cfg_rdata(crd),
    .i_suspend_request_n(req_n), .i_maskable_interrupt(mi), .i_mgmt_interrupt_n(smi_n),
    .i_pci_master_request_n(preq_n), .o_suspend_ack_n(ack_n), .o_pm_packet_out(line),
    .i_halt_exec(halt), .i_maskable_interrupt_enabled(ien), .i_core_idle(idle), .i_pend_service(psv),
    .o_maskable_interrupt_pending(ipend), .o_smi_pending(spend), .o_core_stall(stall), .i_pci_master_busy(busy),
    .i_halt_cycle_done(hdone), .o_halt_cycle_req(hreq), .i_refresh_active(refr),
    .i_self_refresh_ack(sra), .i_gfx_pipe_active(gfx), .o_self_refresh_req(srq),
    .o_clocks_stop(cstop), .i_pm_events(ev));

  psq_companion psq_companion_i (
    .i_clk(clk), .i_rst_n(rst_n), .i_want(want), .i_line(line),
    .o_req_n(req_n), .o_word(word), .o_got(got));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic finish_test;
    if (n_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  task automatic tick(input int k = 1);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  // register strobes get a quiet cycle after each access
  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    addr = a;
    wd = d;
    wr = 1'b1;
    tick();
    wr = 1'b0;
    tick();
  endtask : wr_reg

  task automatic rd_reg(input logic [15:0] a, input logic [31:0] x);
    addr = a;
    rd = 1'b1;
    rq.push_back(x);
    tick();
    rd = 1'b0;
    tick();
  endtask : rd_reg

  // bounded wait for a level, then compare it
  task automatic wfor(input string nm, ref logic s, input logic x, input int lim);
    n = 0;
    while (s !== x && n < lim) begin
      tick();
      n++;
    end
    chk(nm, {31'h0, s}, {31'h0, x});
  endtask : wfor

  task automatic wait_got;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (got !== 1'b1 && n < 400);
    // got stands for one cycle only, so look before leaving the edge
    chk("frame", {31'h0, got}, 32'h1);
    #1;
  endtask : wait_got

  // read data settles one cycle after the strobe
  always @(posedge clk) rdv <= rd;
  always @(negedge clk) if (rdv && rq.size() > 0) chk("rdata", rdata, rq.pop_front());
  always @(posedge clk) if (got === 1'b1 && pq.size() > 0) chk("packet", {24'h0, word}, pq.pop_front());

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    tick(4);
    rst_n = 1'b1;
    rd_reg(PSQ_OFS_INTERVAL, 32'h0);
    rd_reg(PSQ_OFS_CLK_STOP, 32'h0);
    rd_reg(PSQ_OFS_PACKET, 32'h0);
    rd_reg(16'h8510, 32'h0);
    wait_got();
    // each interval code: fresh packet, then an emptied one
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      e = 8'($random(seed));
      wr_reg(PSQ_OFS_PACKET, {24'h0, v});
      ev = e;
      tick();
      ev = 8'h0;
      pq.push_back({24'h0, v | e});
      wr_reg(PSQ_OFS_INTERVAL, {24'hffffff, 3'h0, 2'(i), 3'h0});
      rd_reg(PSQ_OFS_INTERVAL, {24'h0, 3'h0, 2'(i), 3'h0});
      rd_reg(PSQ_OFS_PACKET, {24'h0, v | e});
      wait_got();
      t = cyc;
      pq.push_back(32'h0);
      wait_got();
      g = cyc - t - int'(ivl[i]);
      chk("interval", 32'(g >= 0 && g <= 2), 32'h1);
    end
    want = 1'b1;
    halt = 1'b1;
    tick();
    halt = 1'b0;
    tick(8);
    chk("ack", {31'h0, ack_n}, 32'h1);
    want = 1'b0;
    cwd = 8'h88;
    cwr = 1'b1;
    tick();
    cwr = 1'b0;
    chk("cfg", {24'h0, crd}, 32'h88);
    idle = 1'b0;
    want = 1'b1;
    tick(8);
    chk("ack", {31'h0, ack_n}, 32'h1);
    idle = 1'b1;
    wfor("ack", ack_n, 1'b0, 4);
    chk("stall", {31'h0, stall}, 32'h1);
    preq_n = 1'b0;
    wfor("ack", ack_n, 1'b1, 4);
    busy = 1'b1;
    tick(4);
    busy = 1'b0;
    preq_n = 1'b1;
    wfor("ack", ack_n, 1'b0, 5);
    mi = 1'b1;
    smi_n = 1'b0;
    tick(4);
    mi = 1'b0;
    smi_n = 1'b1;
    refr = 1'b1;
    want = 1'b0;
    tick(6);
    // ack lifts at once; a running refresh only keeps the core stalled
    chk("ack", {30'h0, stall, ack_n}, 32'h3);
    refr = 1'b0;
    wfor("ack", ack_n, 1'b1, 3);
    chk("pending", {30'h0, ipend, spend}, 32'h3);
    psv = 1'b1;
    tick();
    psv = 1'b0;
    tick();
    chk("pending", {29'h0, stall, ipend, spend}, 32'h0);
    want = 1'b1;
    wfor("ack", ack_n, 1'b0, 6);
    want = 1'b0;
    wfor("ack", ack_n, 1'b1, 4);
    // halt with a master busy first, then a clean halt
    for (int b = 1; b >= 0; b--) begin
      busy = 1'(b);
      halt = 1'b1;
      tick();
      halt = 1'b0;
      wfor("hreq", hreq, 1'b1, 5);
      tick(3);
      chk("ack", {31'h0, ack_n}, 32'h1);
      hdone = 1'b1;
      tick();
      hdone = 1'b0;
      tick(3);
      chk("ack", {31'h0, ack_n}, 32'(b));
      busy = 1'b0;
      wfor("ack", ack_n, 1'b0, 3);
      // a masked interrupt must leave the halt suspend alone
      ien = 1'b0;
      mi = 1'b1;
      tick(5);
      chk("ack", {31'h0, ack_n}, 32'h0);
      ien = 1'(b);
      mi = 1'(b);
      smi_n = 1'(b);
      wfor("ack", ack_n, 1'b1, 7);
      tick(6);
      mi = 1'b0;
      smi_n = 1'b1;
    end
    wr_reg(PSQ_OFS_CLK_STOP, 32'h1);
    gfx = 1'b1;
    want = 1'b1;
    tick(10);
    chk("deep", {30'h0, srq, ack_n}, 32'h1);
    gfx = 1'b0;
    wfor("srq", srq, 1'b1, 10);
    sra = 1'b1;
    wfor("ack", ack_n, 1'b0, 5);
    chk("cstop", {31'h0, cstop}, 32'h1);
    mi = 1'b1;
    tick(8);
    mi = 1'b0;
    chk("ack", {31'h0, ack_n}, 32'h0);
    run = 1'b0;
    #1000;
    run = 1'b1;
    tick(2);
    want = 1'b0;
    tick(4);
    sra = 1'b0;
    wfor("ack", ack_n, 1'b1, 5);
    finish_test();
  end
endmodule : psq_suspend_ctrl_bench

//--- logic/psq_pkg.sv
package psq_pkg;

  // system clock rate
  localparam int          PSQ_CLK_MHZ        = 20;

  // register offsets in the memory-mapped power management space
  localparam logic [15:0] PSQ_OFS_INTERVAL   = 16'h8504;
  localparam logic [15:0] PSQ_OFS_CLK_STOP   = 16'h8508;
  localparam logic [15:0] PSQ_OFS_PACKET     = 16'h850c;
  // configuration index of config_control_two
  localparam logic [7:0]  PSQ_IDX_CFG_TWO    = 8'hc2;

  // field positions
  localparam int          PSQ_BIT_HALT_EN    = 3;
  localparam int          PSQ_BIT_PIN_EN     = 7;
  localparam int          PSQ_BIT_CLK_STOP   = 0;
  localparam int          PSQ_IVL_LSB        = 3;
  localparam int          PSQ_IVL_MSB        = 4;

  // reset values
  localparam logic [7:0]  PSQ_RST_CFG_TWO    = 8'h00;
  localparam logic [7:0]  PSQ_RST_INTERVAL   = 8'h00;
  localparam logic [7:0]  PSQ_RST_CLK_STOP   = 8'h00;
  localparam logic [7:0]  PSQ_RST_PACKET     = 8'h00;

  // packet interval choices in microseconds, selected by the interval field
  localparam int          PSQ_IVL0_US        = 1;
  localparam int          PSQ_IVL1_US        = 2;
  localparam int          PSQ_IVL2_US        = 5;
  localparam int          PSQ_IVL3_US        = 10;
  localparam logic [7:0]  PSQ_IVL0_CYC       = 8'(PSQ_IVL0_US * PSQ_CLK_MHZ);
  localparam logic [7:0]  PSQ_IVL1_CYC       = 8'(PSQ_IVL1_US * PSQ_CLK_MHZ);
  localparam logic [7:0]  PSQ_IVL2_CYC       = 8'(PSQ_IVL2_US * PSQ_CLK_MHZ);
  localparam logic [7:0]  PSQ_IVL3_CYC       = 8'(PSQ_IVL3_US * PSQ_CLK_MHZ);

  // serial framing lengths in clocks
  localparam logic [2:0]  PSQ_START_CYC      = 3'h2;
  localparam logic [2:0]  PSQ_LAST_BIT       = 3'h7;

  // suspend sequencer states
  typedef enum logic [3:0] {
    PSQ_RUN, PSQ_HALT_BCAST, PSQ_HALT_WAIT_PCI, PSQ_HALT_SUSPEND_REQUEST_N, PSQ_PIN_DRAIN,
    PSQ_PIN_SUSPEND_REQUEST_N, PSQ_PIN_PCI, PSQ_DEEP_REFRESH, PSQ_DEEP_STOP, PSQ_EXIT_WAIT
  } psq_state_t;

  // serializer states
  typedef enum logic [1:0] {
    PSQ_SER_IDLE, PSQ_SER_START, PSQ_SER_DATA, PSQ_SER_END
  } psq_ser_state_t;

endpackage : psq_pkg

//--- logic/psq_pkt_buf.sv
// two-entry buffer between packet snapshot and serializer
module psq_pkt_buf
  import psq_pkg::*;
(
  // clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  // fill side
  input  wire logic       i_valid,
  input  wire logic [7:0] i_word,
  output logic            o_ready,
  // drain side
  psq_pkt_if.src          out
);

  logic [7:0] mem_q [2];
  logic [7:0] mem_d [2];
  logic       wp_q, wp_d, rp_q, rp_d;
  logic [1:0] cnt_q, cnt_d;
  logic       push, pop;

  // honest full and empty flags give back-pressure to the interval counter
  always_comb begin
    o_ready   = (cnt_q != 2'h2);
    out.valid = (cnt_q != 2'h0);
    out.word  = mem_q[rp_q];
    push      = i_valid && o_ready;
    pop       = out.valid && out.ready;
    mem_d     = mem_q;
    if (push) begin
      mem_d[wp_q] = i_word;
    end
    wp_d  = push ? ~wp_q : wp_q;
    rp_d  = pop ? ~rp_q : rp_q;
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      mem_q[0] <= 8'h00;
      mem_q[1] <= 8'h00;
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

endmodule : psq_pkt_buf

//--- logic/psq_pkt_if.sv
// carries packet words from the two-entry buffer to the serializer
interface psq_pkt_if;
  logic [7:0] word;
  logic       valid;
  logic       ready;
  logic       done;
  logic [7:0] sent;

  modport src (output word, output valid, input ready, input done, input sent);
  modport ser (input word, input valid, output ready, output done, output sent);
endinterface : psq_pkt_if

//--- logic/psq_serializer.sv
// frames one packet: start marker, eight bits msb first, end marker
module psq_serializer
  import psq_pkg::*;
(
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  // packet words
  psq_pkt_if.ser    in,
  // serial line
  output logic      o_line
);

  psq_ser_state_t st_q, st_d;
  logic [7:0]     sh_q, sh_d;
  logic [2:0]     cnt_q, cnt_d;
  logic           line_q, line_d;

  always_comb begin
    st_d     = st_q;
    sh_d     = sh_q;
    cnt_d    = cnt_q;
    line_d   = 1'b0;
    in.ready = (st_q == PSQ_SER_IDLE);
    in.done  = 1'b0;
    in.sent  = sh_q;
    case (st_q)
      PSQ_SER_IDLE: begin
        if (in.valid) begin
          sh_d   = in.word;
          // count from zero: this cycle and the next one form the marker
          cnt_d  = 3'h0;
          line_d = 1'b1;
          st_d   = PSQ_SER_START;
        end
      end
      PSQ_SER_START: begin
        if (cnt_q == PSQ_START_CYC - 3'h1) begin
          line_d = sh_q[7];
          cnt_d  = 3'h0;
          st_d   = PSQ_SER_DATA;
        end else begin
          line_d = 1'b1;
          cnt_d  = cnt_q + 3'h1;
        end
      end
      PSQ_SER_DATA: begin
        // one bit per clock
        if (cnt_q == PSQ_LAST_BIT) begin
          line_d = 1'b1;
          st_d   = PSQ_SER_END;
        end else begin
          cnt_d  = cnt_q + 3'h1;
          line_d = sh_q[3'h6 - cnt_q];
        end
      end
      PSQ_SER_END: begin
        in.done = 1'b1;
        st_d    = PSQ_SER_IDLE;
      end
      default: st_d = PSQ_SER_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      st_q   <= PSQ_SER_IDLE;
      sh_q   <= 8'h00;
      cnt_q  <= 3'h0;
      line_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      sh_q   <= sh_d;
      cnt_q  <= cnt_d;
      line_q <= line_d;
    end
  end

  assign o_line = line_q;

endmodule : psq_serializer

//--- logic/psq_suspend_ctrl.sv
// Behaviour
// - halt with halt_suspend_enable set enters halt-initiated suspend
// - halt broadcast cycle completes before suspend_ack_n goes low
// - interrupt or management interrupt ends halt suspend within six clocks
// - pci master activity during halt suspend holds suspend_ack_n inactive
// - pci access in progress at halt delays suspend_ack_n until done
// - suspend_request_n honoured only with suspend_pin_enable set
// - core drains instructions and bus cycles before pin suspend ack
// - suspend_request_n sampled on every rising system clock edge
// - request sampled inactive releases ack within two clocks or after refresh; code lifts ack at once, a refresh only holds the stall
// - one interrupt and one management interrupt latched during pin suspend
// - pci request in pin suspend releases ack to serve master
// - pci done and request withdrawn re-enters suspend if still requested
// - pci access in progress at request delays ack until done
// - clock stop with graphics active ignores request, no deep suspend
// - deep entry puts sdram in self refresh then stops internal clocks
// - deep suspend leaves only on request deassertion after clock restart
// - events gather in 8-bit packet, sent every 1 to 10 us by bits 4:3
// - line low until interval expires, then high two clocks as start
// - packet bits shift out msb first, bit 7 to bit 0
// - end marker high one clock, then low until next interval
// - packet register cleared once transmission finishes; code clears only the bits sent, later events stay
module psq_suspend_ctrl
  import psq_pkg::*;
(
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  // memory-mapped power management registers
  input  wire logic        i_reg_wr_en,
  input  wire logic        i_reg_rd_en,
  input  wire logic [15:0] i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  output logic      [31:0] o_reg_rdata,
  // configuration register port
  input  wire logic        i_cfg_wr_en,
  input  wire logic [7:0]  i_cfg_index,
  input  wire logic [7:0]  i_cfg_wdata,
  output logic      [7:0]  o_cfg_rdata,
  // pins from the companion and the system
  input  wire logic        i_suspend_request_n,
  input  wire logic        i_maskable_interrupt,
  input  wire logic        i_mgmt_interrupt_n,
  input  wire logic        i_pci_master_request_n,
  output logic             o_suspend_ack_n,
  output logic             o_pm_packet_out,
  // core side
  input  wire logic        i_halt_exec,
  input  wire logic        i_maskable_interrupt_enabled,
  input  wire logic        i_core_idle,
  input  wire logic        i_pend_service,
  output logic             o_maskable_interrupt_pending,
  output logic             o_smi_pending,
  output logic             o_core_stall,
  // pci controller
  input  wire logic        i_pci_master_busy,
  input  wire logic        i_halt_cycle_done,
  output logic             o_halt_cycle_req,
  // memory controller, graphics and clock gating
  input  wire logic        i_refresh_active,
  input  wire logic        i_self_refresh_ack,
  input  wire logic        i_gfx_pipe_active,
  output logic             o_self_refresh_req,
  output logic             o_clocks_stop,
  // processor events for the packet
  input  wire logic [7:0]  i_pm_events
);

  // two-flop synchronisers for pin inputs: req, maskable_interrupt, smi, pci request
  logic [3:0] meta_q, sync_q;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      meta_q <= 4'hd;
      sync_q <= 4'hd;
    end else begin
      meta_q <= {i_pci_master_request_n, i_mgmt_interrupt_n,
                 i_maskable_interrupt, i_suspend_request_n};
      sync_q <= meta_q;
    end
  end

  logic req_on, maskable_interrupt_on, smi_on, pci_req_on, pci_act;
  always_comb begin
    req_on     = !sync_q[0];
    maskable_interrupt_on    = sync_q[1] && i_maskable_interrupt_enabled;
    smi_on     = !sync_q[2];
    pci_req_on = !sync_q[3];
    pci_act    = pci_req_on || i_pci_master_busy;
  end

  // register state
  logic [7:0] cfg_q, cfg_d, ivl_q, ivl_d, cstp_q, cstp_d, pkt_q, pkt_d;
  logic       halt_en, pin_en, cstp_en;
  logic       pkt_wr, sent_done;
  logic [7:0] sent_word;

  always_comb begin
    halt_en = cfg_q[PSQ_BIT_HALT_EN];
    pin_en  = cfg_q[PSQ_BIT_PIN_EN];
    cstp_en = cstp_q[PSQ_BIT_CLK_STOP];
    cfg_d   = cfg_q;
    ivl_d   = ivl_q;
    cstp_d  = cstp_q;
    pkt_wr  = i_reg_wr_en && (i_reg_addr == PSQ_OFS_PACKET);
    if (i_cfg_wr_en && (i_cfg_index == PSQ_IDX_CFG_TWO)) begin
      cfg_d = i_cfg_wdata;
    end
    if (i_reg_wr_en && (i_reg_addr == PSQ_OFS_INTERVAL)) begin
      ivl_d = i_reg_wdata[7:0];
    end
    if (i_reg_wr_en && (i_reg_addr == PSQ_OFS_CLK_STOP)) begin
      cstp_d = i_reg_wdata[7:0];
    end
    // only the bits that were sent are cleared, so events arriving
    // during a transmission or in the clearing cycle survive
    pkt_d = pkt_q;
    if (sent_done) begin
      pkt_d = pkt_q & ~sent_word;
    end
    if (pkt_wr) begin
      pkt_d = i_reg_wdata[7:0];
    end
    pkt_d = pkt_d | i_pm_events;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cfg_q  <= PSQ_RST_CFG_TWO;
      ivl_q  <= PSQ_RST_INTERVAL;
      cstp_q <= PSQ_RST_CLK_STOP;
      pkt_q  <= PSQ_RST_PACKET;
    end else begin
      cfg_q  <= cfg_d;
      ivl_q  <= ivl_d;
      cstp_q <= cstp_d;
      pkt_q  <= pkt_d;
    end
  end

  // read data registered; unmapped addresses read zero
  logic [31:0] rdata_q, rdata_d;
  always_comb begin
    rdata_d = rdata_q;
    if (i_reg_rd_en) begin
      case (i_reg_addr)
        PSQ_OFS_INTERVAL: rdata_d = {24'h000000, ivl_q};
        PSQ_OFS_CLK_STOP: rdata_d = {24'h000000, cstp_q};
        PSQ_OFS_PACKET:   rdata_d = {24'h000000, pkt_q};
        default:          rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_cfg_rdata = cfg_q;

  // interval counter; it waits at zero while the buffer is full
  logic [7:0] icnt_q, icnt_d, reload;
  logic       snap_valid, snap_ready;
  always_comb begin
    case (ivl_q[PSQ_IVL_MSB:PSQ_IVL_LSB])
      2'h0:    reload = PSQ_IVL0_CYC;
      2'h1:    reload = PSQ_IVL1_CYC;
      2'h2:    reload = PSQ_IVL2_CYC;
      default: reload = PSQ_IVL3_CYC;
    endcase
    snap_valid = (icnt_q == 8'h00);
    icnt_d     = icnt_q;
    if (snap_valid) begin
      if (snap_ready) begin
        icnt_d = reload - 8'h01;
      end
    end else begin
      icnt_d = icnt_q - 8'h01;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      icnt_q <= PSQ_IVL0_CYC;
    end else begin
      icnt_q <= icnt_d;
    end
  end

  psq_pkt_if pkt_bus ();

  psq_pkt_buf u_buf (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_valid    (snap_valid),
    .i_word     (pkt_q),
    .o_ready    (snap_ready),
    .out        (pkt_bus.src)
  );

  psq_serializer u_ser (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .in         (pkt_bus.ser),
    .o_line     (o_pm_packet_out)
  );

  assign sent_done = pkt_bus.done;
  assign sent_word = pkt_bus.sent;

  // suspend sequencer
  psq_state_t st_q, st_d;
  logic       ack_q, ack_d;
  logic       pi_q, pi_d, ps_q, ps_d;
  logic       pin_suspend_request_n;

  always_comb begin
    st_d = st_q;
    case (st_q)
      PSQ_RUN: begin
        if (i_halt_exec && halt_en) begin
          st_d = PSQ_HALT_BCAST;
        end else if (req_on && pin_en) begin
          // graphics still running blocks a deep request entirely
          if (!(cstp_en && i_gfx_pipe_active)) begin
            st_d = PSQ_PIN_DRAIN;
          end
        end
      end
      PSQ_HALT_BCAST: begin
        if (i_halt_cycle_done) begin
          st_d = PSQ_HALT_WAIT_PCI;
        end
      end
      PSQ_HALT_WAIT_PCI: begin
        if (maskable_interrupt_on || smi_on) begin
          st_d = PSQ_RUN;
        end else if (!i_pci_master_busy) begin
          st_d = PSQ_HALT_SUSPEND_REQUEST_N;
        end
      end
      PSQ_HALT_SUSPEND_REQUEST_N: begin
        if (maskable_interrupt_on || smi_on) begin
          st_d = i_refresh_active ? PSQ_EXIT_WAIT : PSQ_RUN;
        end
      end
      PSQ_PIN_DRAIN: begin
        if (!req_on || !pin_en) begin
          st_d = PSQ_RUN;
        end else if (i_core_idle && !pci_act) begin
          st_d = cstp_en ? PSQ_DEEP_REFRESH : PSQ_PIN_SUSPEND_REQUEST_N;
        end
      end
      PSQ_PIN_SUSPEND_REQUEST_N: begin
        if (!req_on) begin
          st_d = i_refresh_active ? PSQ_EXIT_WAIT : PSQ_RUN;
        end else if (pci_req_on) begin
          st_d = PSQ_PIN_PCI;
        end
      end
      PSQ_PIN_PCI: begin
        if (!pci_act) begin
          st_d = req_on ? PSQ_PIN_SUSPEND_REQUEST_N : PSQ_RUN;
        end
      end
      PSQ_DEEP_REFRESH: begin
        if (i_self_refresh_ack) begin
          st_d = PSQ_DEEP_STOP;
        end
      end
      PSQ_DEEP_STOP: begin
        // nothing but the request going away is looked at here; an edge
        // arriving at all means the outside clock runs again
        if (!req_on) begin
          st_d = PSQ_EXIT_WAIT;
        end
      end
      PSQ_EXIT_WAIT: begin
        if (!i_refresh_active && !i_self_refresh_ack) begin
          st_d = PSQ_RUN;
        end
      end
      default: st_d = PSQ_RUN;
    endcase

    // ack low only in a settled suspend state; in halt suspend pci activity lifts it
    ack_d = (st_d == PSQ_HALT_SUSPEND_REQUEST_N && !pci_act)
         || (st_d == PSQ_PIN_SUSPEND_REQUEST_N)
         || (st_d == PSQ_DEEP_STOP);

    // one interrupt and one management interrupt held across pin suspend;
    // the service clear acts only outside pin suspend, where no new event is latched
    pin_suspend_request_n = (st_q == PSQ_PIN_DRAIN) || (st_q == PSQ_PIN_SUSPEND_REQUEST_N)
            || (st_q == PSQ_PIN_PCI) || (st_q == PSQ_DEEP_STOP);
    pi_d = pi_q;
    ps_d = ps_q;
    if (i_pend_service && !pin_suspend_request_n) begin
      pi_d = 1'b0;
      ps_d = 1'b0;
    end
    if (pin_suspend_request_n && sync_q[1]) begin
      pi_d = 1'b1;
    end
    if (pin_suspend_request_n && smi_on) begin
      ps_d = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      st_q  <= PSQ_RUN;
      ack_q <= 1'b0;
      pi_q  <= 1'b0;
      ps_q  <= 1'b0;
    end else begin
      st_q  <= st_d;
      ack_q <= ack_d;
      pi_q  <= pi_d;
      ps_q  <= ps_d;
    end
  end

  // outputs from state
  assign o_suspend_ack_n    = !ack_q;
  assign o_halt_cycle_req   = (st_q == PSQ_HALT_BCAST);
  assign o_core_stall       = (st_q != PSQ_RUN);
  assign o_self_refresh_req = (st_q == PSQ_DEEP_REFRESH) || (st_q == PSQ_DEEP_STOP);
  assign o_clocks_stop      = (st_q == PSQ_DEEP_STOP);
  assign o_maskable_interrupt_pending     = pi_q && !pin_suspend_request_n;
  assign o_smi_pending      = ps_q && !pin_suspend_request_n;

endmodule : psq_suspend_ctrl
